// ---- include/tpc_pkg.sv ----
// Shared constants for the transmit phase compensation buffer.
// Assumes one include per compile unit; users write tpc_pkg::name.
package tpc_pkg;

    // Datapath geometry
    localparam int DATA_W     = 20;   // Widest fabric word
    localparam int FIFO_DEPTH = 4;    // Compensation buffer words
    localparam int SYM_8      = 8;    // Flip group for 8/16-bit words
    localparam int SYM_10     = 10;   // Flip group for 10/20-bit words

    // Fabric word width selection
    localparam logic [1:0] WSEL_8  = 2'h0;
    localparam logic [1:0] WSEL_10 = 2'h1;
    localparam logic [1:0] WSEL_16 = 2'h2;
    localparam logic [1:0] WSEL_20 = 2'h3;

    localparam logic [DATA_W-1:0] MASK_8  = 20'h000ff;
    localparam logic [DATA_W-1:0] MASK_10 = 20'h003ff;
    localparam logic [DATA_W-1:0] MASK_16 = 20'h0ffff;
    localparam logic [DATA_W-1:0] MASK_20 = 20'hfffff;

    // Upper-layer interface revision 2.00, major and minor nibbles
    localparam logic [7:0] PIPE_REV = 8'h20;

    // Bit-flip reference pair
    localparam logic [DATA_W-1:0] FLIP_EX_IN  = 20'h0bcad;
    localparam logic [DATA_W-1:0] FLIP_EX_OUT = 20'h03db5;

    // Source of the word handed to the byte serializer
    typedef enum logic [0:0] {
        MODE_NORMAL = 1'b0,
        MODE_REG    = 1'b1
    } tpc_mode_t;

    // Valid bits of a word at the selected width
    function automatic logic [DATA_W-1:0] tpc_mask(input logic [1:0] wsel);
        logic [DATA_W-1:0] m;
        case (wsel)
            WSEL_8:  m = MASK_8;
            WSEL_10: m = MASK_10;
            WSEL_16: m = MASK_16;
            default: m = MASK_20;
        endcase
        return m;
    endfunction : tpc_mask

    // Optional bit-flip inside each symbol, then width masking
    function automatic logic [DATA_W-1:0] tpc_shape(
        input logic [DATA_W-1:0] d,
        input logic [1:0]        wsel,
        input logic              flip);
        logic [DATA_W-1:0] f;
        int                s;
        int                idx;
        f   = d;
        idx = 0;
        s   = (wsel == WSEL_10 || wsel == WSEL_20) ? SYM_10 : SYM_8;
        if (flip) begin
            for (int i = 0; i < DATA_W; i++) begin
                idx = (i / s) * s + s - 1 - (i % s);
                f[i] = (idx < DATA_W) ? d[idx] : 1'b0;
            end
        end
        return f & tpc_mask(wsel);
    endfunction : tpc_shape

endpackage : tpc_pkg

// ---- hdl/tpc_sync.sv ----
// Two-stage synchroniser for a bundle of levels.
// Assumes each bit is a level or gray code changing one bit at a time.
`timescale 1ns/1ps
module tpc_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             resetN,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } tpc_sync_t;

    tpc_sync_t s_r;
    tpc_sync_t s_nxt;

    // First stage feeds only the second one
    always_comb begin
        s_nxt.stage1 = d;
        s_nxt.stage2 = s_r.stage1;
        if (!resetN) begin
            s_nxt = {RST_VAL, RST_VAL};
        end
    end

    always_ff @(posedge clk) begin
        s_r <= s_nxt;
    end

    assign q = s_r.stage2;

endmodule : tpc_sync

// ---- hdl/tpc_fifo.sv ----
// Dual-clock FIFO with gray-coded pointers, valid/ready on both sides.
// Assumes DEPTH is a power of two, at least four; resets are synchronous
// to their own clocks.
`timescale 1ns/1ps
module tpc_fifo #(
    parameter int WIDTH = tpc_pkg::DATA_W,
    parameter int DEPTH = tpc_pkg::FIFO_DEPTH
) (
    input  wire logic             wrClk,
    input  wire logic             wrResetN,
    input  wire logic             wrValid,
    output logic                  wrReady,
    input  wire logic [WIDTH-1:0] wrData,
    input  wire logic             rdClk,
    input  wire logic             rdResetN,
    output logic                  rdValid,
    input  wire logic             rdReady,
    output logic      [WIDTH-1:0] rdData
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] bin;
        logic [AW:0] gray;
        logic        ready;
    } tpc_wside_t;

    typedef struct packed {
        logic [AW:0] bin;
        logic [AW:0] gray;
    } tpc_rside_t;

    tpc_wside_t       w_r;
    tpc_wside_t       w_nxt;
    tpc_rside_t       r_r;
    tpc_rside_t       r_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      rGraySync;
    logic [AW:0]      wGraySync;
    logic             wrEn;
    logic             rdEn;

    function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction : bin2gray

    function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
        logic [AW:0] b;
        b[AW] = g[AW];
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : gray2bin

    ////////////////////////////////////////////////////////////////////////
    // Pointer crossings: only gray codes cross, one bit moves per step
    tpc_sync #(.WIDTH(AW + 1)) uRdToWr (
        .clk    (wrClk),
        .resetN (wrResetN),
        .d      (r_r.gray),
        .q      (rGraySync)
    );

    tpc_sync #(.WIDTH(AW + 1)) uWrToRd (
        .clk    (rdClk),
        .resetN (rdResetN),
        .d      (w_r.gray),
        .q      (wGraySync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write side; full is judged on a stale read pointer, so it is safe
    assign wrEn = wrValid && w_r.ready;

    always_comb begin
        w_nxt = w_r;
        if (wrEn) begin
            w_nxt.bin  = w_r.bin + 1'b1;
            w_nxt.gray = bin2gray(w_nxt.bin);
        end
        w_nxt.ready = w_nxt.gray !=
            {~rGraySync[AW:AW-1], rGraySync[AW-2:0]};
        if (!wrResetN) begin
            w_nxt = '0;
        end
    end

    always_ff @(posedge wrClk) begin
        w_r <= w_nxt;
    end

    // Storage holds exactly DEPTH words
    always_ff @(posedge wrClk) begin
        if (wrEn) begin
            mem[w_r.bin[AW-1:0]] <= wrData;
        end
    end

    assign wrReady = w_r.ready;

    ////////////////////////////////////////////////////////////////////////
    // Read side; data is shown as soon as the pointers differ
    assign rdValid = r_r.gray != wGraySync;
    assign rdEn    = rdValid && rdReady;
    assign rdData  = mem[r_r.bin[AW-1:0]];

    always_comb begin
        r_nxt = r_r;
        if (rdEn) begin
            r_nxt.bin  = r_r.bin + 1'b1;
            r_nxt.gray = bin2gray(r_nxt.bin);
        end
        if (!rdResetN) begin
            r_nxt = '0;
        end
    end

    always_ff @(posedge rdClk) begin
        r_r <= r_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_depth_bound: assert property (@(posedge rdClk) disable iff (!rdResetN)
        (AW + 1)'(gray2bin(wGraySync) - r_r.bin) <= DEPTH)
        else $error("fifo occupancy above depth");

    a_gray_step: assert property (@(posedge rdClk) disable iff (!rdResetN)
        $onehot0(wGraySync ^ $past(wGraySync)))
        else $error("write pointer moved more than one gray bit");

    a_wr_hold: assert property (@(posedge wrClk) disable iff (!wrResetN)
        wrValid && !wrReady |=> $stable(w_r.bin))
        else $error("write pointer moved while full");

    c_fifo_full: cover property (@(posedge wrClk) disable iff (!wrResetN)
        wrValid && !wrReady);

endmodule : tpc_fifo

// ---- hdl/tpc_tx_phase_comp.sv ----
// Transmit phase compensation stage at the entry of a serial channel.
// Assumes wrClk is the fabric interface clock and clk the channel's
// low-speed parallel clock; configuration inputs are quasi-static.
`timescale 1ns/1ps

// Notes on behaviour
// - Absorb phase offset between fabric write clock and parallel read clock.
// - Compensation buffer holds exactly four words of channel width.
// - Normal mode delivers each word after two to three parallel cycles.
// - Registered option adds only one parallel cycle, for fixed latency.
// - Fabric word width selectable as 8, 10, 16 or 20 bits.
// - Data order: this buffer, byte serializer, encoder, serializer, driver.
// - Upper-layer interface follows revision 2.00 of the published definition.
// - Optional bit-flip reverses bits inside each byte, or each 10-bit symbol at 10/20-bit widths, before buffering.
module tpc_tx_phase_comp #(
    parameter int DATA_W = tpc_pkg::DATA_W,
    parameter int DEPTH  = tpc_pkg::FIFO_DEPTH
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              wrClk,
    input  wire logic              wrValid,
    output logic                   wrReady,
    input  wire logic [DATA_W-1:0] wrData,
    input  wire logic [1:0]        widthSel,
    input  wire logic              bitFlipEn,
    input  wire logic              regModeEn,
    output logic      [DATA_W-1:0] serData,
    output logic                   serValid,
    input  wire logic              serReady,
    output logic      [7:0]        pipeRevision
);

    ////////////////////////////////////////////////////////////////////////
    // Types and signals

    // Read-side state of the output stage
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              valid;
        tpc_pkg::tpc_mode_t mode;
        logic [7:0]        pipeRev;
    } tpc_out_t;

    tpc_out_t          o_r;
    tpc_out_t          o_nxt;

    logic              wrResetN;
    logic [3:0]        cfgW;
    logic [3:0]        cfgR;
    logic [1:0]        wselW;
    logic [1:0]        wselR;
    logic              flipW;
    logic              flipR;
    logic              regModeW;
    logic              regModeR;
    logic [DATA_W-1:0] shapedW;
    logic              fifoWrValid;
    logic              fifoRdValid;
    logic              fifoRdReady;
    logic [DATA_W-1:0] fifoRdData;

    ////////////////////////////////////////////////////////////////////////
    // Reset and configuration crossings

    // Write side reset follows reset_n, two fabric edges late
    tpc_sync #(.WIDTH(1)) uRstSync (
        .clk    (wrClk),
        .resetN (1'b1),
        .d      (reset_n),
        .q      (wrResetN)
    );

    // Config copies for each clock, so neither side reads a raw pin
    tpc_sync #(.WIDTH(4)) uCfgW (
        .clk    (wrClk),
        .resetN (wrResetN),
        .d      ({regModeEn, bitFlipEn, widthSel}),
        .q      (cfgW)
    );

    tpc_sync #(.WIDTH(4)) uCfgR (
        .clk    (clk),
        .resetN (reset_n),
        .d      ({regModeEn, bitFlipEn, widthSel}),
        .q      (cfgR)
    );

    // Field split of the two config copies
    assign wselW    = cfgW[1:0];
    assign flipW    = cfgW[2];
    assign regModeW = cfgW[3];
    assign wselR    = cfgR[1:0];
    assign flipR    = cfgR[2];
    assign regModeR = cfgR[3];

    ////////////////////////////////////////////////////////////////////////
    // Write side: shaping before the buffer

    // Flip and width mask are applied on entry, so stored words are final
    assign shapedW = tpc_pkg::tpc_shape(wrData, wselW, flipW);

    // In registered mode the buffer is bypassed and stays idle
    assign fifoWrValid = wrValid && !regModeW;

    ////////////////////////////////////////////////////////////////////////
    // Compensation buffer between the two clocks

    tpc_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (DEPTH)
    ) uFifo (
        .wrClk    (wrClk),
        .wrResetN (wrResetN),
        .wrValid  (fifoWrValid),
        .wrReady  (wrReady),
        .wrData   (shapedW),
        .rdClk    (clk),
        .rdResetN (reset_n),
        .rdValid  (fifoRdValid),
        .rdReady  (fifoRdReady),
        .rdData   (fifoRdData)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read side: output register toward the byte serializer

    // Pop only when the output register is free or being drained;
    // the synchroniser plus this register give the 2-3 cycle latency
    assign fifoRdReady = (o_r.mode == tpc_pkg::MODE_NORMAL)
                         && (!o_r.valid || serReady);

    // Next value of the output stage
    always_comb begin
        o_nxt         = o_r;
        o_nxt.pipeRev = tpc_pkg::PIPE_REV;
        o_nxt.mode    = regModeR ? tpc_pkg::MODE_REG
                                 : tpc_pkg::MODE_NORMAL;
        case (o_r.mode)
            tpc_pkg::MODE_REG: begin
                // Fixed latency: both clocks share one source here,
                // so the word is taken one edge after it is offered
                o_nxt.valid = wrValid;
                o_nxt.data  = tpc_pkg::tpc_shape(wrData, wselR,
                                                 flipR);
            end
            tpc_pkg::MODE_NORMAL: begin
                if (fifoRdReady) begin
                    o_nxt.valid = fifoRdValid;
                    o_nxt.data  = fifoRdData;
                end
            end
            default: begin
                o_nxt.valid = 1'b0;
            end
        endcase
        if (!reset_n) begin
            o_nxt.data    = '0;
            o_nxt.valid   = 1'b0;
            o_nxt.mode    = tpc_pkg::MODE_NORMAL;
            o_nxt.pipeRev = tpc_pkg::PIPE_REV;
        end
    end

    // State register of the read-side output stage
    always_ff @(posedge clk) begin
        o_r <= o_nxt;
    end

    // Outputs come straight from the state register
    assign serData      = o_r.data;
    assign serValid     = o_r.valid;
    assign pipeRevision = o_r.pipeRev;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the parallel clock

    // Registered mode: one edge from offer to output
    a_reg_latency: assert property (@(posedge clk) disable iff (!reset_n)
        o_r.mode == tpc_pkg::MODE_REG
        |=> serValid == $past(wrValid))
        else $error("registered mode latency is not one cycle");

    // Bit-flip reference pair at 16 bits
    a_flip_example: assert property (@(posedge clk) disable iff (!reset_n)
        o_r.mode == tpc_pkg::MODE_REG && flipR
        && wselR == tpc_pkg::WSEL_16 && wrValid
        && wrData == tpc_pkg::FLIP_EX_IN
        |=> serData == tpc_pkg::FLIP_EX_OUT)
        else $error("byte bit-flip gave the wrong word");

    // Nothing above the selected width leaves while wselR is stable
    a_width_clean: assert property (@(posedge clk) disable iff (!reset_n)
        serValid && $stable(wselR)
        |-> (serData & ~tpc_pkg::tpc_mask(wselR)) == '0)
        else $error("bits set above the selected width");

    // A pop from the buffer shows at the output on the next edge
    a_norm_take: assert property (@(posedge clk) disable iff (!reset_n)
        fifoRdValid && fifoRdReady
        |=> serValid && serData == $past(fifoRdData))
        else $error("popped word did not reach the output");

    // In normal mode a stalled word is held, never dropped or replaced
    a_stall_hold: assert property (@(posedge clk) disable iff (!reset_n)
        o_r.mode == tpc_pkg::MODE_NORMAL && regModeR == 1'b0
        && serValid && !serReady
        |=> serValid && $stable(serData))
        else $error("stalled output word changed");

    // Scenarios worth seeing
    c_reg_xfer: cover property (@(posedge clk) disable iff (!reset_n)
        o_r.mode == tpc_pkg::MODE_REG && wrValid ##1 serValid);

    c_norm_xfer: cover property (@(posedge clk) disable iff (!reset_n)
        fifoRdValid && fifoRdReady ##1 serValid && serReady);

    c_stall: cover property (@(posedge clk) disable iff (!reset_n)
        serValid && !serReady ##1 serValid && serReady);

endmodule : tpc_tx_phase_comp

// ---- sim/tpc_writer_model.sv ----
// Behavioural fabric writer that feeds the compensation buffer.
// Assumes the bench pushes words into pend; one word per handshake.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module tpc_writer_model (
    input  wire logic        wrClk,
    input  wire logic        wrReady,
    output logic             wrValid,
    output logic [19:0]      wrData
);
    logic [19:0] pend[$];  // Words still to be offered
    time         lastTake; // Edge that accepted the latest word
    int          taken;    // Words accepted since time zero

    // Idle start, nothing offered
    initial begin
        wrValid  = 1'h0;
        wrData   = 20'h00000;
        lastTake = 0;
        taken    = 0;
    end

    // Hold each word until an edge sees wrReady, then move on
    always @(posedge wrClk) begin
        if (wrValid && wrReady) begin
            void'(pend.pop_front());
            taken++;
            lastTake = $time;
        end
        #2;
        wrValid = (pend.size() != 0);
        // Released data toggles so a stale word never passes for a new one
        wrData = wrValid ? pend[0] : ~wrData;
    end
endmodule : tpc_writer_model

// ---- sim/tpc_tx_phase_comp_tb.sv ----
// Self-checking bench for the transmit phase compensation stage.
// Assumes the writer model beside it; clocks equal, phases unrelated.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module tpc_tx_phase_comp_tb;
    logic             clk;
    logic             wrClkRaw;
    logic             sameClk;
    logic             reset_n;
    logic             serReady;
    logic             bitFlipEn;
    logic             regModeEn;
    logic [1:0]       widthSel;
    wire logic        wrClk;
    wire logic        wrValid;
    wire logic        wrReady;
    wire logic        serValid;
    wire logic [19:0] wrData;
    wire logic [19:0] serData;
    wire logic [7:0]  pipeRevision;
    int               failCount;
    int               totalChecks;
    int               cycles;

    // Registered mode needs one shared clock, so the write clock follows
    assign wrClk = sameClk ? clk : wrClkRaw;

    // Both clocks 50 ns, write clock offset by 17 ns
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    initial begin
        wrClkRaw = 1'h0;
        #17;
        forever #25 wrClkRaw = ~wrClkRaw;
    end

    tpc_tx_phase_comp i_dut (
        .clk          (clk),
        .reset_n      (reset_n),
        .wrClk        (wrClk),
        .wrValid      (wrValid),
        .wrReady      (wrReady),
        .wrData       (wrData),
        .widthSel     (widthSel),
        .bitFlipEn    (bitFlipEn),
        .regModeEn    (regModeEn),
        .serData      (serData),
        .serValid     (serValid),
        .serReady     (serReady),
        .pipeRevision (pipeRevision)
    );

    tpc_writer_model i_writer (
        .wrClk   (wrClk),
        .wrReady (wrReady),
        .wrValid (wrValid),
        .wrData  (wrData)
    );

    ////////////////////////////////////////////////////////////////////
    // Comparison, expectation and closing helpers
    task automatic check(input string what, input logic [19:0] exp,
                         input logic [19:0] got);
        totalChecks++;
        if (got !== exp) begin
            failCount++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Own reckoning of flip then mask; groups are 8 or 10 bits wide
    function automatic logic [19:0] expect_word(input logic [19:0] d,
                                                input int sel,
                                                input int flip);
        logic [19:0] r;
        int          g;
        int          w;
        int          j;
        w = (sel == 0) ? 8 : (sel == 1) ? 10 : (sel == 2) ? 16 : 20;
        g = (w == 10 || w == 20) ? 10 : 8;
        r = d;
        if (flip != 0) begin
            for (int i = 0; i < 20; i++) begin
                j    = (i / g) * g + g - 1 - i % g;
                r[i] = (j < 20) ? d[j] : 1'h0;
            end
        end
        return r & 20'((21'h1 << w) - 1);
    endfunction : expect_word

    task automatic complete_run;
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    // Reset with a fresh static configuration, then wait for space
    task automatic do_reset(input logic [1:0] sel, input logic flip,
                            input logic rm);
        int n;
        @(posedge clk);
        #2;
        reset_n   = 1'h0;
        widthSel  = sel;
        bitFlipEn = flip;
        regModeEn = rm;
        sameClk   = rm;
        serReady  = 1'h1;
        i_writer.pend.delete();
        repeat (8) @(posedge clk);
        #2;
        check("serValid in reset", 20'h0, serValid);
        check("serData in reset", 20'h0, serData);
        check("wrReady in reset", 20'h0, wrReady);
        check("revision code", 20'h20, pipeRevision);
        reset_n = 1'h1;
        n = 0;
        while (wrReady !== 1'h1 && n < 30) begin
            @(posedge clk);
            #2;
            n++;
        end
        check("wrReady after reset", 20'h1, wrReady);
    endtask : do_reset

    // Wait for an offered output word; tV is the edge that raised it
    task automatic get_word(output logic [19:0] w, output time tV);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (serValid !== 1'h1 && n < 40);
        tV = $time - 1;
        w  = serData;
        check("serValid arrives", 20'h1, serValid);
    endtask : get_word

    ////////////////////////////////////////////////////////////////////
    // Every width with and without flip, plus latency in normal mode
    task automatic test_widths;
        logic [19:0] w;
        time         tV;
        int          lat;
        for (int s = 0; s < 4; s++) begin
            for (int f = 0; f < 2; f++) begin
                do_reset(2'(s), 1'(f), 1'h0);
                i_writer.pend.push_back(20'hfbcad);
                get_word(w, tV);
                check("shaped word", expect_word(20'hfbcad, s, f), w);
                lat = int'((tV - i_writer.lastTake + 49) / 50);
                check("latency two to three", 20'h1,
                      20'(lat >= 2 && lat <= 3));
                if (s == 2 && f == 1) begin
                    check("flip example", 20'h03db5, w);
                end
            end
        end
    endtask : test_widths

    // Stall the reader: buffer must refuse after four, then drain in order
    task automatic test_fill;
        logic [19:0] w;
        time         tV;
        int          base;
        do_reset(2'h3, 1'h0, 1'h0);
        serReady = 1'h0;
        base     = i_writer.taken;
        for (int k = 0; k < 8; k++) begin
            i_writer.pend.push_back(20'ha5a50 + 20'(k));
        end
        repeat (20) @(posedge clk);
        #2;
        check("wrReady when full", 20'h0, wrReady);
        // Four in the buffer, one more may sit in the output register
        check("words held while stalled", 20'h1,
              20'(i_writer.taken - base >= 4 &&
                  i_writer.taken - base <= 5));
        // Word 0 already stands in the output register. Raising serReady
        // drains it at the next edge, so it must be read before that edge.
        check("stalled word valid", 20'h1, serValid);
        check("word order", 20'ha5a50, serData);
        serReady = 1'h1;
        for (int k = 1; k < 8; k++) begin
            get_word(w, tV);
            check("word order", 20'ha5a50 + 20'(k), w);
        end
        check("writer queue empty", 20'h0, 20'(i_writer.pend.size()));
    endtask : test_fill

    // Registered mode: one cycle, no back-pressure, single-cycle valid
    task automatic test_registered;
        logic [19:0] w;
        time         tV;
        do_reset(2'h2, 1'h1, 1'h1);
        serReady = 1'h0;
        i_writer.pend.push_back(tpc_pkg::FLIP_EX_IN);
        get_word(w, tV);
        check("registered latency", 20'h1,
              20'(tV == i_writer.lastTake));
        check("registered word", tpc_pkg::FLIP_EX_OUT, w);
        @(posedge clk);
        #1;
        check("registered valid one cycle", 20'h0, serValid);
    endtask : test_registered

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        reset_n     = 1'h0;
        serReady    = 1'h1;
        widthSel    = 2'h0;
        bitFlipEn   = 1'h0;
        regModeEn   = 1'h0;
        sameClk     = 1'h0;
        failCount   = 0;
        totalChecks = 0;
        cycles      = 0;
        repeat (5) @(posedge clk);
        test_widths;
        test_fill;
        test_registered;
        complete_run;
    end

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failCount++;
            $display("wrong value run length expected %0d seen %0d",
                     4999, cycles);
            complete_run;
        end
    end
endmodule : tpc_tx_phase_comp_tb
